/* common/lmq_pkg.sv */
// constants, offsets and layouts for the legacy mmio queue register bank
// assumes a 32-bit word-aligned register port driven by driver software
package lmq_pkg;
  localparam logic [11:0] OFS_MAGIC      = 12'h000;
  localparam logic [11:0] OFS_REVISION   = 12'h004;
  localparam logic [11:0] OFS_KIND       = 12'h008;
  localparam logic [11:0] OFS_MAKER      = 12'h00c;
  localparam logic [11:0] OFS_OFFER      = 12'h010;
  localparam logic [11:0] OFS_OFFER_WIN  = 12'h014;
  localparam logic [11:0] OFS_ACCEPT     = 12'h020;
  localparam logic [11:0] OFS_ACCEPT_WIN = 12'h024;
  localparam logic [11:0] OFS_GRANULE    = 12'h028;
  localparam logic [11:0] OFS_RING_PICK  = 12'h030;
  localparam logic [11:0] OFS_DEPTH_LIM  = 12'h034;
  localparam logic [11:0] OFS_DEPTH      = 12'h038;
  localparam logic [11:0] OFS_BOUNDARY   = 12'h03c;
  localparam logic [11:0] OFS_PAGE_NUM   = 12'h040;
  localparam logic [11:0] OFS_PENDING    = 12'h060;
  localparam logic [11:0] OFS_CLEAR      = 12'h064;
  localparam logic [11:0] OFS_STATUS     = 12'h070;
  // fixed identity words
  localparam logic [31:0] MAGIC_WORD     = 32'h5c3a91e6; // arbitrary value
  localparam logic [31:0] LEGACY_REV     = 32'h0000000b; // arbitrary value
  // pending-event field layout
  localparam int          EVT_USED_BIT   = 0;
  localparam int          EVT_CFG_BIT    = 1;
  localparam int          EVT_W          = 2;
  // reset values
  localparam logic [31:0] GRANULE_RST    = 32'h00001000;
  localparam logic [31:0] BOUNDARY_RST   = 32'h00001000;
  localparam logic [31:0] ZERO_WORD      = 32'h00000000;
endpackage : lmq_pkg

/* rtl/lmq_ring_slots.sv */
`timescale 1ns/1ps
// per-ring storage: depth, boundary and page number for each ring
// assumes the bank decodes writes and gives the picked ring index
module lmq_ring_slots
  import lmq_pkg::*;
#(
  parameter int RINGS = 4,
  parameter int IDX_W = 2
) (
  input  wire logic             clk,       // bank clock
  input  wire logic             rst,       // sync reset, active high
  input  wire logic [IDX_W-1:0] pick,      // ring in use by accesses
  input  wire logic             pick_ok,   // picked ring exists
  input  wire logic             wr_depth,  // depth write strobe
  input  wire logic             wr_bound,  // boundary write strobe
  input  wire logic             wr_page,   // page number write strobe
  input  wire logic             clr_pages, // clear every page number
  input  wire logic [31:0]      wdata,     // write data
  input  wire logic [IDX_W-1:0] rd_idx,    // ring looked up for address
  output logic      [31:0]      page_rd,   // page number of picked ring
  output logic      [31:0]      depth_rd,  // depth of looked-up ring
  output logic      [31:0]      bound_rd,  // boundary of looked-up ring
  output logic      [31:0]      page_lk    // page of looked-up ring
);
  // refuse a ring count that the index cannot reach
  if (RINGS < 1 || RINGS > (1 << IDX_W)) begin : g_bad_rings
    $error("lmq_ring_slots: ring count does not fit the index");
  end

  logic [31:0] depth_r [RINGS];
  logic [31:0] bound_r [RINGS];
  logic [31:0] page_r  [RINGS];

  // one slot per ring, written only when that ring is picked; clr_pages zeroes every page slot
  for (genvar g = 0; g < RINGS; g++) begin : g_slot
    always_ff @(posedge clk) begin
      if (rst || clr_pages) begin
        page_r[g] <= ZERO_WORD;
      end else if (wr_page && pick_ok && pick == IDX_W'(g)) begin
        page_r[g] <= wdata;
      end
    end
    always_ff @(posedge clk) begin
      if (rst) begin
        depth_r[g] <= ZERO_WORD;
        bound_r[g] <= BOUNDARY_RST;
      end else if (pick_ok && pick == IDX_W'(g)) begin
        if (wr_depth) depth_r[g] <= wdata;
        if (wr_bound) bound_r[g] <= wdata;
      end
    end
  end

  // read-back of the picked ring and lookup for the address unit
  always_comb begin
    page_rd  = pick_ok ? page_r[pick] : ZERO_WORD;
    depth_rd = depth_r[rd_idx];
    bound_rd = bound_r[rd_idx];
    page_lk  = page_r[rd_idx];
  end
endmodule // lmq_ring_slots

/* rtl/lmq_bank.sv */
`timescale 1ns/1ps
// legacy page-addressed register bank with interrupt line
// assumes single-cycle 32-bit aligned accesses synchronous to clk
module lmq_bank
  import lmq_pkg::*;
#(
  parameter int          RINGS      = 4,
  parameter int          IDX_W      = 2,
  parameter int          FEAT_WORDS = 2,
  parameter logic [31:0] KIND_CODE  = 32'h00000002, // arbitrary value
  parameter logic [31:0] MAKER      = 32'h0000abcd, // arbitrary value
  parameter logic [31:0] DEPTH_MAX  = 32'h00000100
) (
  input  wire logic                  clk,         // bank clock
  input  wire logic                  rst,         // sync reset, active high
  input  wire logic                  reg_wr,      // write strobe, one cycle
  input  wire logic                  reg_rd,      // read strobe, one cycle
  input  wire logic [11:0]           reg_addr,    // byte offset
  input  wire logic [31:0]           reg_wdata,   // write data
  output logic      [31:0]           reg_rdata,   // read data, registered
  output logic                       reg_rvalid,  // read data valid pulse
  input  wire logic [FEAT_WORDS*32-1:0] offer_feats, // device feature set
  input  wire logic [EVT_W-1:0]      event_set,   // event pulses in
  input  wire logic [IDX_W-1:0]      addr_ring,   // ring for address query
  output logic      [63:0]           ring_addr,   // ring guest byte address
  output logic      [31:0]           ring_depth_o,// depth of that ring
  output logic      [31:0]           ring_bound_o,// boundary of that ring
  output logic      [FEAT_WORDS*32-1:0] accept_feats, // activated features
  output logic      [31:0]           status_o,    // driver progress flags
  output logic                       soft_reset,  // status-zero reset pulse
  output logic                       irq          // interrupt line
);
  // refuse parameter values that decode and storage cannot serve
  if (IDX_W < 1 || RINGS < 1 || RINGS > (1 << IDX_W)) begin : g_bad_rings
    $error("lmq_bank: ring count does not fit the index");
  end
  // the offered word is picked by five selector bits
  if (FEAT_WORDS < 1 || FEAT_WORDS > 32) begin : g_bad_feats
    $error("lmq_bank: feature word count out of range");
  end

  logic [31:0]           offer_win_r;
  logic [31:0]           accept_win_r;
  logic [31:0]           granule_r;
  logic [31:0]           pick_r;
  logic [31:0]           status_r;
  logic [EVT_W-1:0]      pending_r;
  logic [FEAT_WORDS*32-1:0] accept_r;
  logic                  soft_reset_r;
  logic [31:0]           rdata_nxt;
  logic                  pick_ok;
  logic [31:0]           page_rd;
  logic [31:0]           page_lk;
  logic [31:0]           depth_rd;
  logic [31:0]           bound_rd;

  // decode a write strobe for one offset
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    return a == o;
  endfunction

  assign pick_ok = pick_r < 32'(RINGS);

  // offered capability word selector
  always_ff @(posedge clk) begin
    if (rst) begin
      offer_win_r <= ZERO_WORD;
    end else if (reg_wr && hit(reg_addr, OFS_OFFER_WIN)) begin
      offer_win_r <= reg_wdata;
    end
  end

  // accepted capability word selector
  always_ff @(posedge clk) begin
    if (rst) begin
      accept_win_r <= ZERO_WORD;
    end else if (reg_wr && hit(reg_addr, OFS_ACCEPT_WIN)) begin
      accept_win_r <= reg_wdata;
    end
  end

  // page granule used to scale ring page numbers
  always_ff @(posedge clk) begin
    if (rst) begin
      granule_r <= GRANULE_RST;
    end else if (reg_wr && hit(reg_addr, OFS_GRANULE)) begin
      granule_r <= reg_wdata;
    end
  end

  // ring pick; later ring accesses follow it
  always_ff @(posedge clk) begin
    if (rst) begin
      pick_r <= ZERO_WORD;
    end else if (reg_wr && hit(reg_addr, OFS_RING_PICK)) begin
      pick_r <= reg_wdata;
    end
  end

  // accepted capability words, one per selector value
  for (genvar w = 0; w < FEAT_WORDS; w++) begin : g_acc
    always_ff @(posedge clk) begin
      if (rst) begin
        accept_r[w*32 +: 32] <= ZERO_WORD;
      end else if (reg_wr && hit(reg_addr, OFS_ACCEPT) &&
                   accept_win_r == 32'(w)) begin
        accept_r[w*32 +: 32] <= reg_wdata;
      end
    end
  end

  // status register; zero write gives a one-cycle device reset
  always_ff @(posedge clk) begin
    if (rst) begin
      status_r     <= ZERO_WORD;
      soft_reset_r <= 1'b0;
    end else begin
      soft_reset_r <= 1'b0;
      if (reg_wr && hit(reg_addr, OFS_STATUS)) begin
        if (reg_wdata == ZERO_WORD) begin
          status_r     <= ZERO_WORD;
          soft_reset_r <= 1'b1;
        end else begin
          status_r <= status_r | reg_wdata;
        end
      end
    end
  end

  // sticky pending flags; a new event wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      pending_r <= '0;
    end else if (reg_wr && hit(reg_addr, OFS_CLEAR)) begin
      pending_r <= (pending_r & ~reg_wdata[EVT_W-1:0]) | event_set;
    end else begin
      pending_r <= pending_r | event_set;
    end
  end

  // line follows flags, so it drops the cycle after the last clear
  assign irq = |pending_r;

  lmq_ring_slots #(
    .RINGS (RINGS),
    .IDX_W (IDX_W)
  ) u_slots (
    .clk       (clk),
    .rst       (rst),
    .pick      (pick_r[IDX_W-1:0]),
    .pick_ok   (pick_ok),
    .wr_depth  (reg_wr && hit(reg_addr, OFS_DEPTH)),
    .wr_bound  (reg_wr && hit(reg_addr, OFS_BOUNDARY)),
    .wr_page   (reg_wr && hit(reg_addr, OFS_PAGE_NUM)),
    .clr_pages (soft_reset_r),
    .wdata     (reg_wdata),
    .rd_idx    (addr_ring),
    .page_rd   (page_rd),
    .depth_rd  (depth_rd),
    .bound_rd  (bound_rd),
    .page_lk   (page_lk)
  );

  // read mux; write-only and unmapped offsets read zero
  always_comb begin
    rdata_nxt = ZERO_WORD;
    case (reg_addr)
      OFS_MAGIC:     rdata_nxt = MAGIC_WORD;
      OFS_REVISION:  rdata_nxt = LEGACY_REV;
      OFS_KIND:      rdata_nxt = KIND_CODE;
      OFS_MAKER:     rdata_nxt = MAKER;
      OFS_OFFER: begin
        if (offer_win_r < 32'(FEAT_WORDS)) begin
          rdata_nxt = offer_feats[offer_win_r[4:0]*32 +: 32];
        end
      end
      OFS_DEPTH_LIM: rdata_nxt = pick_ok ? DEPTH_MAX : ZERO_WORD;
      OFS_PAGE_NUM:  rdata_nxt = page_rd;
      OFS_PENDING:   rdata_nxt = {{(32-EVT_W){1'b0}}, pending_r};
      OFS_STATUS:    rdata_nxt = status_r;
      default:       rdata_nxt = ZERO_WORD;
    endcase
  end

  // registered read answer, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata  <= ZERO_WORD;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) reg_rdata <= rdata_nxt;
    end
  end

  // guest byte address, depth and boundary of the looked-up ring
  always_ff @(posedge clk) begin
    if (rst) begin
      ring_addr    <= 64'h0;
      ring_depth_o <= ZERO_WORD;
      ring_bound_o <= BOUNDARY_RST;
    end else begin
      ring_addr    <= 64'(page_lk) * 64'(granule_r);
      ring_depth_o <= depth_rd;
      ring_bound_o <= bound_rd;
    end
  end

  assign accept_feats = accept_r;
  assign status_o     = status_r;
  assign soft_reset   = soft_reset_r;
endmodule // lmq_bank

/* test/lmq_bank_asserts.sv */
// concurrent checks on the ports of the legacy queue register bank
// assumes binding onto lmq_bank, single clock, sync reset high
`timescale 1ns/1ps
module lmq_bank_asserts
  import lmq_pkg::*;
(
  input wire logic        clk,        // bank clock
  input wire logic        rst,        // sync reset
  input wire logic        reg_wr,     // write strobe
  input wire logic        reg_rd,     // read strobe
  input wire logic [11:0] reg_addr,   // byte offset
  input wire logic [31:0] reg_wdata,  // write data
  input wire logic [31:0] reg_rdata,  // read data
  input wire logic        reg_rvalid, // read valid
  input wire logic [1:0]  event_set,  // event pulses
  input wire logic        soft_reset, // status-zero pulse
  input wire logic        irq         // interrupt line
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // read answers and identity words
  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe gave no valid");
  magic_word_a: assert property (reg_rd && reg_addr == OFS_MAGIC
    |=> reg_rdata == MAGIC_WORD) else $error("bad signature word");
  legacy_rev_a: assert property (
    reg_rd && reg_addr == OFS_REVISION |=> reg_rdata == LEGACY_REV)
    else $error("bad revision word");
  // interrupt line against pending flags, and the status-zero reset pulse
  irq_raise_a: assert property (|event_set |=> irq)
    else $error("event did not raise interrupt");
  irq_hold_a: assert property (
    irq && !(reg_wr && reg_addr == OFS_CLEAR) |=> irq)
    else $error("interrupt dropped without clear");
  irq_quiet_a: assert property (!irq && event_set == 2'h0 |=> !irq)
    else $error("interrupt rose without event");
  irq_drop_a: assert property (
    irq && reg_wr && reg_addr == OFS_CLEAR && reg_wdata[1:0] == 2'h3
    && event_set == 2'h0 |=> !irq)
    else $error("interrupt stayed after full clear");
  status_rst_a: assert property (reg_wr && reg_addr == OFS_STATUS
    && reg_wdata == 32'h0 |=> soft_reset) else $error("no soft reset");
  // main scenarios reached
  cover property (reg_wr && reg_addr == OFS_CLEAR && irq);
  cover property ($fell(irq));
  cover property (irq && reg_wr && reg_addr == OFS_CLEAR
    && reg_wdata[1:0] == 2'h3);
  cover property (soft_reset);
endmodule // lmq_bank_asserts

bind lmq_bank lmq_bank_asserts u_lmq_chk (.clk(clk), .rst(rst),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .event_set(event_set), .soft_reset(soft_reset), .irq(irq));

/* test/lmq_bank_tb_top.sv */
// self-checking bench for the legacy queue register bank
// assumes reads answer one cycle after the strobe, writes act at once
`timescale 1ns/1ps
module lmq_bank_tb_top
  import lmq_pkg::*;
();
  typedef struct packed {logic wr; logic [11:0] a; logic [31:0] d;} lmq_row_t;
  logic        clk, rst, reg_wr, reg_rd, reg_rvalid, soft_reset, irq;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, ring_depth_o, ring_bound_o, status_o;
  logic [63:0] offer_feats, ring_addr, accept_feats;
  logic [1:0]  event_set, addr_ring;
  int          errors = 0;
  int          comparisons = 0;
  // ordinary accesses: write rows, or read rows with expected data
  lmq_row_t rows [16] = '{
    '{1'b0, OFS_MAGIC, MAGIC_WORD}, '{1'b0, OFS_REVISION, LEGACY_REV},
    '{1'b0, OFS_KIND, 32'h5}, '{1'b0, OFS_MAKER, 32'hbeef},
    '{1'b1, OFS_MAGIC, 32'h0}, '{1'b0, OFS_MAGIC, MAGIC_WORD},
    '{1'b1, OFS_OFFER_WIN, 32'h1}, '{1'b0, OFS_OFFER, 32'h0f0f0f0f},
    '{1'b1, OFS_OFFER_WIN, 32'h0}, '{1'b0, OFS_OFFER, 32'ha5a5a5a5},
    '{1'b1, OFS_RING_PICK, 32'h4}, '{1'b0, OFS_DEPTH_LIM, 32'h0},
    '{1'b1, OFS_RING_PICK, 32'h1}, '{1'b0, OFS_DEPTH_LIM, 32'h100},
    '{1'b1, OFS_PAGE_NUM, 32'h30}, '{1'b0, OFS_PAGE_NUM, 32'h30}};

  // identity codes handed in here are arbitrary
  lmq_bank #(.KIND_CODE(32'h5), .MAKER(32'hbeef)) DUT (.clk(clk),
    .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .offer_feats(offer_feats), .event_set(event_set),
    .addr_ring(addr_ring), .ring_addr(ring_addr),
    .ring_depth_o(ring_depth_o), .ring_bound_o(ring_bound_o),
    .accept_feats(accept_feats), .status_o(status_o),
    .soft_reset(soft_reset), .irq(irq));

  // compare one result, count it, report a mismatch
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one register write, strobe held for a single edge
  task automatic put(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // one register read, answer sampled a cycle after the strobe
  task automatic get(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rvalid, 1'b1);
    check(reg_rdata, exp);
  endtask
  // counts, verdict and end of run
  task automatic test_done;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // watchdog against a hang
  initial begin
    repeat (4000) @(posedge clk);
    $display("wrong value at %0t: watchdog ran out", $time);
    errors++;
    test_done;
  end
  // main sequence
  initial begin
    {rst, reg_wr, reg_rd, event_set, addr_ring} = 7'h40;
    reg_addr = 12'h0;
    reg_wdata = 32'h0;
    offer_feats = 64'h0f0f0f0f_a5a5a5a5;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    check({irq, status_o}, 33'h0);
    check(ring_bound_o, BOUNDARY_RST);
    foreach (rows[i])
      if (rows[i].wr) put(rows[i].a, rows[i].d);
      else get(rows[i].a, rows[i].d);
    // both events, then clear them one at a time
    @(posedge clk);
    event_set <= 2'h3;
    @(posedge clk);
    event_set <= 2'h0;
    #1;
    check(irq, 1'b1);
    get(OFS_PENDING, 32'h3);
    put(OFS_CLEAR, 32'h1);
    check(irq, 1'b1);
    get(OFS_PENDING, 32'h2);
    put(OFS_CLEAR, 32'h2);
    check(irq, 1'b0);
    // both events again, one full clear drops the line
    @(posedge clk);
    event_set <= 2'h3;
    @(posedge clk);
    event_set <= 2'h0;
    put(OFS_CLEAR, 32'h3);
    check(irq, 1'b0);
    // ring placement and shape of ring 1
    put(OFS_GRANULE, 32'h200);
    put(OFS_DEPTH, 32'h40);
    put(OFS_BOUNDARY, 32'h80);
    @(posedge clk);
    addr_ring <= 2'h1;
    repeat (2) @(posedge clk);
    #1;
    check(ring_addr, 64'h6000);
    check(ring_depth_o, 32'h40);
    check(ring_bound_o, 32'h80);
    // accepted words land in the picked window
    put(OFS_ACCEPT_WIN, 32'h1);
    put(OFS_ACCEPT, 32'h1234);
    put(OFS_ACCEPT_WIN, 32'h0);
    put(OFS_ACCEPT, 32'h55);
    check(accept_feats, 64'h1234_00000055);
    // progress flags, then a status-zero reset
    put(OFS_STATUS, 32'h3);
    check(status_o, 32'h3);
    put(OFS_STATUS, 32'h0);
    check(soft_reset, 1'b1);
    put(OFS_RING_PICK, 32'h1);
    get(OFS_PAGE_NUM, 32'h0);
    check(status_o, 32'h0);
    // reset in mid-run with an event pending
    @(posedge clk);
    event_set <= 2'h1;
    @(posedge clk);
    event_set <= 2'h0;
    rst <= 1'b1;
    #1;
    check(irq, 1'b1);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    check(irq, 1'b0);
    check(ring_bound_o, BOUNDARY_RST);
    get(OFS_PENDING, 32'h0);
    test_done;
  end
endmodule // lmq_bank_tb_top
